/* File: logic/plc_phy_tx_gain_and_timebase.sv */
`timescale 1ns/1ps
module plc_phy_tx_gain_and_timebase
    import phy_gain_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [15:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // transmit sample stream
    input  wire logic [15:0] tx_sample_in,
    input  wire logic        tx_sample_valid,
    input  wire logic        tx_in_preamble,
    output logic [15:0]      tx_sample_out,
    output logic             tx_sample_out_valid,
    output logic             tx_start,
    input  wire logic        tx_done,
    // receive measurements from the demodulator
    input  wire logic        rx_preamble_seen,
    input  wire logic        rx_corr_valid,
    input  wire logic [15:0] rx_corr_level,
    input  wire logic        rx_symbol_valid,
    input  wire logic [7:0]  rx_symbol_strength,
    input  wire logic        rx_msg_end
);
    // transmit scheduling: idle, armed and waiting for the instant, sending
    typedef enum logic [1:0] {
        TX_IDLE    = 2'b00,
        TX_ARMED   = 2'b01,
        TX_SENDING = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [7:0]          global_gain;
        logic [7:0]          pre_gain;
        logic [7:0]          body_gain;
        logic [TIME_W-1:0]   start_time;
        tx_state_t           tx_state;
        logic [TIME_W-1:0]   rx_stamp;
        logic [15:0]         rx_corr;
        logic [7:0]          str_min;
        logic [7:0]          str_avg;
        logic [7:0]          run_min;
        logic [STR_ACC_W-1:0] run_acc;
        logic [STR_CNT_W-1:0] run_cnt;
        logic [31:0]         rdata;
        logic                ack;
        logic                start_p;
    } state_t;
    state_t st_reg, st_next;

    logic [TIME_W-1:0]    now;
    logic [31:0]          rd_mux;
    logic                 bus_req;
    logic                 bus_take;
    logic                 wr_take;
    logic                 hit_global;
    logic                 hit_pre;
    logic                 hit_body;
    logic                 hit_time;
    logic                 hit_order;
    logic                 order_wr;
    logic                 order_rd;
    logic                 time_hit;
    logic [7:0]           cur_min;
    logic [STR_ACC_W-1:0] cur_acc;
    logic [STR_CNT_W-1:0] cur_cnt;
    logic [STR_ACC_W-1:0] avg_full;

    gain_if gs_if ();

    phy_timebase u_timebase (
        .clk     (clk),
        .reset_n (reset_n),
        .now     (now)
    );

    gain_stage u_gain (
        .clk     (clk),
        .reset_n (reset_n),
        .g       (gs_if.chain)
    );

    // section gain picked by where the sample lies in the frame
    assign gs_if.sample       = tx_sample_in;
    assign gs_if.valid        = tx_sample_valid;
    assign gs_if.preamble     = tx_in_preamble;
    assign gs_if.global_gain  = st_reg.global_gain;
    assign gs_if.section_gain = gs_if.preamble ? st_reg.pre_gain
                                               : st_reg.body_gain;

    assign tx_sample_out       = gs_if.out_sample;
    assign tx_sample_out_valid = gs_if.out_valid;
    assign tx_start            = st_reg.start_p;

    // bus handshake: one wait cycle on every access, then the answer
    assign bus_req  = read || write;
    assign bus_take = bus_req && !st_reg.ack;
    assign wr_take  = write && st_reg.ack;

    // write decode on the full byte address; unmapped writes fall through
    assign hit_global = wr_take && (address == OFS_GLOBAL_GAIN);
    assign hit_pre    = wr_take && (address == OFS_PRE_GAIN);
    assign hit_body   = wr_take && (address == OFS_BODY_GAIN);
    assign hit_time   = wr_take && (address == OFS_START_TIME);
    assign hit_order  = wr_take && (address == OFS_ORDER);
    assign order_wr   = writedata[ORDER_BIT];

    // order bit reads zero only while the frame is really going out
    assign order_rd = (st_reg.tx_state != TX_SENDING);

    // timebase match against the scheduled instant
    assign time_hit = (now == st_reg.start_time);

    // read mux; time fields read with the 20 bits left aligned, low 12 zero
    always_comb begin
        rd_mux = 32'h0;
        case (address)
            OFS_GLOBAL_GAIN: rd_mux = {24'h0, st_reg.global_gain};
            OFS_PRE_GAIN:    rd_mux = {24'h0, st_reg.pre_gain};
            OFS_BODY_GAIN:   rd_mux = {24'h0, st_reg.body_gain};
            OFS_START_TIME:  rd_mux = {st_reg.start_time, 12'h0};
            OFS_RX_STAMP:    rd_mux = {st_reg.rx_stamp, 12'h0};
            OFS_FREE_TIMER:  rd_mux = {now, 12'h0};
            OFS_RX_CORR:     rd_mux = {16'h0, st_reg.rx_corr};
            OFS_STR_MIN:     rd_mux = {24'h0, st_reg.str_min};
            OFS_STR_AVG:     rd_mux = {24'h0, st_reg.str_avg};
            OFS_ORDER:       rd_mux = {29'h0, order_rd, 2'b00};
            default:         rd_mux = 32'h0;
        endcase
    end

    // running figures include a symbol that lands with the message end,
    // so the last symbol is not lost when both strobes coincide
    assign cur_min = (rx_symbol_valid && (rx_symbol_strength < st_reg.run_min)) ?
                     rx_symbol_strength : st_reg.run_min;
    assign cur_acc = rx_symbol_valid ? (st_reg.run_acc + STR_ACC_W'(rx_symbol_strength)) :
                     st_reg.run_acc;
    assign cur_cnt = rx_symbol_valid ? (st_reg.run_cnt + 1'b1) : st_reg.run_cnt;
    // count is 8 bits, so a message over 255 symbols averages wrongly
    assign avg_full = (cur_cnt == '0) ? '0 : cur_acc / STR_ACC_W'(cur_cnt);

    // main next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.start_p = 1'b0;

        // read data is taken on the wait cycle and stands until the next access
        if (bus_take) begin
            st_next.ack = 1'b1;
            st_next.rdata = rd_mux;
        end

        // gains and time take effect on the ack edge only
        if (hit_global) begin
            st_next.global_gain = writedata[7:0];
        end
        if (hit_pre) begin
            st_next.pre_gain = writedata[7:0];
        end
        if (hit_body) begin
            st_next.body_gain = writedata[7:0];
        end
        // lanes 3, 2, 1 carry bits 19:12, 11:4 and 3:0 of the instant
        if (hit_time) begin
            if (byteenable[3]) begin
                st_next.start_time[19:12] = writedata[31:24];
            end
            if (byteenable[2]) begin
                st_next.start_time[11:4] = writedata[23:16];
            end
            if (byteenable[1]) begin
                st_next.start_time[3:0] = writedata[15:12];
            end
        end

        // transmit scheduling
        case (st_reg.tx_state)
            TX_IDLE: begin
                // writing zero arms; writing one leaves it idle
                if (hit_order && !order_wr) begin
                    st_next.tx_state = TX_ARMED;
                end
            end
            TX_ARMED: begin
                // a launch wins over a disarm landing in the same cycle
                if (time_hit) begin
                    st_next.tx_state = TX_SENDING;
                    st_next.start_p = 1'b1;
                end else if (hit_order && order_wr) begin
                    st_next.tx_state = TX_IDLE;
                end
            end
            TX_SENDING: begin
                // order writes are refused until the transmitter reports done
                if (tx_done) begin
                    st_next.tx_state = TX_IDLE;
                end
            end
            default: begin
                st_next.tx_state = TX_IDLE;
            end
        endcase

        // receive captures
        if (rx_preamble_seen) begin
            st_next.rx_stamp = now;
        end
        if (rx_corr_valid) begin
            st_next.rx_corr = rx_corr_level;
        end
        // running figures for the message in progress
        st_next.run_min = cur_min;
        st_next.run_acc = cur_acc;
        st_next.run_cnt = cur_cnt;
        // publish at message end, then restart the running figures
        if (rx_msg_end) begin
            st_next.str_min = cur_min;
            st_next.str_avg = avg_full[7:0];
            st_next.run_min = STR_MIN_RESET;
            st_next.run_acc = '0;
            st_next.run_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg             <= '0;
            st_reg.global_gain <= GAIN_RESET;
            st_reg.pre_gain    <= GAIN_RESET;
            st_reg.body_gain   <= GAIN_RESET;
            st_reg.tx_state    <= TX_IDLE;
            st_reg.str_min     <= STR_MIN_RESET;
            st_reg.str_avg     <= STR_AVG_RESET;
            st_reg.run_min     <= STR_MIN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // combinational, so the answer comes exactly one cycle after the request
    assign waitrequest = bus_take;
    assign readdata    = st_reg.rdata;
endmodule // plc_phy_tx_gain_and_timebase

/* File: logic/phy_gain_pkg.sv */
// What this block does
// - global gain scales every transmit sample
// - global 0xff unity, 0x00 silence; the code scales by 255/256 at 0xff
// - preamble gain scales chirp samples, keep 16
// - body gain scales non-preamble samples
// - scheduled start time, 20 bits, 10 us
// - times read upper 20 bits, low zero
// - start transmit when timebase equals scheduled time
// - capture timebase on preamble, read only
// - timebase counts every 10 us, wraps
// - load correlation level when reception starts
// - lowest strength of last message, reset 0xff
// - average strength of last message
// - order bit reads zero once transmitting
package phy_gain_pkg;
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned TICK_US        = 10;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000000 * TICK_US;
    localparam int unsigned TIME_W         = 20;
    localparam int unsigned SAMPLE_W       = 16;
    localparam int unsigned GAIN_W         = 8;
    localparam int unsigned ADDR_W         = 16;
    // byte addresses; some registers share a 32-bit word, so all decode uses the full address
    localparam logic [15:0] OFS_GLOBAL_GAIN = 16'hfe24;
    localparam logic [15:0] OFS_START_TIME  = 16'hfe26;
    localparam logic [15:0] OFS_ORDER       = 16'hfe2a;
    localparam logic [15:0] OFS_RX_STAMP    = 16'hfe2d;
    localparam logic [15:0] OFS_RX_CORR     = 16'hfe31;
    localparam logic [15:0] OFS_STR_MIN     = 16'hfe33;
    localparam logic [15:0] OFS_STR_AVG     = 16'hfe34;
    localparam logic [15:0] OFS_FREE_TIMER  = 16'hfe47;
    localparam logic [15:0] OFS_PRE_GAIN    = 16'hfe9b;
    localparam logic [15:0] OFS_BODY_GAIN   = 16'hfe9c;
    localparam int unsigned ORDER_BIT       = 2;
    localparam logic [7:0]  GAIN_RESET      = 8'hff;
    localparam logic [7:0]  STR_MIN_RESET   = 8'hff;
    localparam logic [7:0]  STR_AVG_RESET   = 8'h00;
    localparam int unsigned STR_ACC_W       = 16;
    localparam int unsigned STR_CNT_W       = 8;
endpackage

/* File: logic/gain_if.sv */
`timescale 1ns/1ps
// sample stream between the gain chain and the scheduling core
interface gain_if;
    logic [15:0] sample;
    logic        valid;
    logic        preamble;
    logic [7:0]  global_gain;
    logic [7:0]  section_gain;
    logic [15:0] out_sample;
    logic        out_valid;
    modport core (output sample, valid, preamble, global_gain, section_gain,
                  input out_sample, out_valid);
    modport chain (input sample, valid, preamble, global_gain, section_gain,
                   output out_sample, out_valid);
endinterface

/* File: logic/gain_stage.sv */
`timescale 1ns/1ps
module gain_stage
    import phy_gain_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // stream
    gain_if.chain    g
);
    typedef struct packed {
        logic [15:0] mid;
        logic        mid_v;
        logic [15:0] out;
        logic        out_v;
    } state_t;
    state_t st_reg, st_next;
    logic [23:0] prod_a;
    logic [23:0] prod_b;

    // section gain first, global gain second; two stages keep multipliers short
    always_comb begin
        st_next = st_reg;
        prod_a = g.sample * g.section_gain;
        prod_b = st_reg.mid * g.global_gain;
        st_next.mid = prod_a[23:8];
        st_next.mid_v = g.valid;
        st_next.out = prod_b[23:8];
        st_next.out_v = st_reg.mid_v;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign g.out_sample = st_reg.out;
    assign g.out_valid  = st_reg.out_v;
endmodule // gain_stage

/* File: logic/phy_timebase.sv */
`timescale 1ns/1ps
module phy_timebase
    import phy_gain_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // time
    output logic [TIME_W-1:0]      now
);
    typedef struct packed {
        logic [15:0]       div;
        logic [TIME_W-1:0] cnt;
    } state_t;
    state_t st_reg, st_next;

    // prescaler makes the 10 us tick; counter wraps naturally at 2^20
    always_comb begin
        st_next = st_reg;
        if (st_reg.div == 16'(TICK_CYCLES - 1)) begin
            st_next.div = '0;
            st_next.cnt = st_reg.cnt + 1'b1;
        end else begin
            st_next.div = st_reg.div + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign now = st_reg.cnt;
endmodule // phy_timebase

/* File: tb/plc_phy_asserts.sv */
`timescale 1ns/1ps
module plc_phy_asserts
    import phy_gain_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // register bus
    input wire logic [15:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // sample stream
    input wire logic [15:0] tx_sample_in,
    input wire logic        tx_sample_valid,
    input wire logic [15:0] tx_sample_out,
    input wire logic        tx_sample_out_valid,
    input wire logic        tx_start
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_wait_one: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait cycle");
    chk_start_gap: assert property (tx_start |=> !tx_start [*8])
        else $error("transmit launch longer than one pulse");
    chk_stream_lat: assert property (tx_sample_valid |-> ##2 tx_sample_out_valid)
        else $error("scaled sample missing two cycles after input");
    chk_no_sample: assert property (!tx_sample_valid |-> ##2 !tx_sample_out_valid)
        else $error("scaled sample without an input");
    chk_zero_in: assert property (tx_sample_valid && tx_sample_in == 16'h0000
        |-> ##2 tx_sample_out == 16'h0000)
        else $error("zero sample not scaled to zero");
    chk_unmapped: assert property (read && !waitrequest && address[15:8] != 8'hfe
        |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_time_pad: assert property (read && !waitrequest && (address == OFS_RX_STAMP
        || address == OFS_FREE_TIMER || address == OFS_START_TIME) |-> readdata[11:0] == 12'h000)
        else $error("time padding bits not zero");
    // read data must stand while the bus is idle
    chk_rd_hold: assert property (!(read || write) ##1 !(read || write) |-> $stable(readdata))
        else $error("read data moved without an access");
endmodule // plc_phy_asserts

bind plc_phy_tx_gain_and_timebase plc_phy_asserts chk (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .tx_sample_in(tx_sample_in),
    .tx_sample_valid(tx_sample_valid), .tx_sample_out(tx_sample_out),
    .tx_sample_out_valid(tx_sample_out_valid), .tx_start(tx_start)
);

/* File: tb/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model
    import phy_gain_pkg::*;
(
    // clock
    input  wire logic        clk,
    // avalon-mm master
    output logic [15:0]      address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // bus idle at time zero
    initial begin
        {read, write, address, writedata, byteenable} = 54'h0;
    end

    // one transfer, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] dv,
                        input logic [3:0] be, output logic [31:0] q);
        int k;
        @(posedge clk);
        {address, writedata, byteenable, read, write} <= {a, dv, be, !w, w};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata;
        if (waitrequest !== 1'b0) begin
            tb.fail_count++;
            tb.stop_test();
        end
        // released lines show the inverse, so stale values cannot pass
        {address, writedata, read, write} <= {~a, ~dv, 2'b00};
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] dv, input logic [3:0] be);
        logic [31:0] q;
        xfer(1'b1, a, dv, be, q);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, 4'hf, q);
    endtask

    // time bytes high to low, then gain, and only then clear the order bit
    task automatic arm(input logic [19:0] t, input logic [7:0] gg);
        wr(OFS_START_TIME, {t, 12'h000}, 4'b1000);
        wr(OFS_START_TIME, {t, 12'h000}, 4'b0100);
        wr(OFS_START_TIME, {t, 12'h000}, 4'b0010);
        wr(OFS_GLOBAL_GAIN, {24'h0, gg}, 4'hf);
        wr(OFS_ORDER, 32'h0, 4'hf);
    endtask
endmodule // cpu_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import phy_gain_pkg::*;
    typedef struct {logic [15:0] s; logic p; logic [7:0] pg, bg, gg;} row_t;
    logic        clk, reset_n, read, write, waitrequest, tx_sample_valid, tx_in_preamble;
    logic        tx_sample_out_valid, tx_start, tx_done, rx_preamble_seen, rx_corr_valid;
    logic        rx_symbol_valid, rx_msg_end;
    logic [15:0] address, tx_sample_in, tx_sample_out, rx_corr_level, mid, ra[9];
    logic [31:0] writedata, readdata, d, e;
    logic [7:0]  rx_symbol_strength, sec, rv[9], st[3];
    logic [3:0]  byteenable;
    logic [19:0] t;
    int          fail_count, n_tests, k;
    row_t        rows[7];

    plc_phy_tx_gain_and_timebase DUT (.clk(clk), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .tx_sample_in(tx_sample_in),
        .tx_sample_valid(tx_sample_valid), .tx_in_preamble(tx_in_preamble),
        .tx_sample_out(tx_sample_out), .tx_sample_out_valid(tx_sample_out_valid),
        .tx_start(tx_start), .tx_done(tx_done), .rx_preamble_seen(rx_preamble_seen),
        .rx_corr_valid(rx_corr_valid), .rx_corr_level(rx_corr_level),
        .rx_symbol_valid(rx_symbol_valid), .rx_symbol_strength(rx_symbol_strength),
        .rx_msg_end(rx_msg_end));
    cpu_model cpu (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest));

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // bounded wait on a design flag, sampled after the edge has settled
    task automatic wait_hi(ref logic s, input int n);
        k = 0;
        while (s !== 1'b1 && k < n) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (s !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    initial begin
        {reset_n, tx_sample_valid, tx_in_preamble, tx_done, rx_preamble_seen} = 5'h0;
        {rx_corr_valid, rx_symbol_valid, rx_msg_end} = 3'h0;
        {tx_sample_in, rx_corr_level, rx_symbol_strength} = 40'h0;
        rows = '{'{16'h8000, 1, 8'hff, 8'h00, 8'hff}, '{16'h8000, 0, 8'h00, 8'hff, 8'hff},
                 '{16'h1234, 1, 8'h00, 8'hff, 8'hff}, '{16'h1234, 0, 8'hff, 8'h00, 8'hff},
                 '{16'hffff, 0, 8'hff, 8'h80, 8'h00}, '{16'h0000, 1, 8'h40, 8'hff, 8'hc0},
                 '{16'hffff, 1, 8'h40, 8'hff, 8'hc0}};
        ra = '{OFS_GLOBAL_GAIN, OFS_START_TIME, OFS_RX_STAMP, OFS_RX_CORR, OFS_STR_MIN,
               OFS_STR_AVG, OFS_PRE_GAIN, OFS_BODY_GAIN, 16'h0100};
        rv = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00};
        st = '{8'h1e, 8'h0a, 8'h14};
        repeat (6) @(posedge clk);
        reset_n <= 1;
        for (int i = 0; i < 9; i++) begin
            cpu.rd(ra[i], d);
            check("reset value", d, {24'h0, rv[i]});
        end
        // gain rows: 24-bit products keep their upper 16 bits
        foreach (rows[i]) begin
            cpu.wr(OFS_PRE_GAIN, {24'h0, rows[i].pg}, 4'hf);
            cpu.wr(OFS_BODY_GAIN, {24'h0, rows[i].bg}, 4'hf);
            cpu.wr(OFS_GLOBAL_GAIN, {24'h0, rows[i].gg}, 4'hf);
            cpu.rd(OFS_PRE_GAIN, d);
            check("preamble gain", d, {24'h0, rows[i].pg});
            @(posedge clk) {tx_sample_in, tx_in_preamble, tx_sample_valid} <= {rows[i].s, rows[i].p, 1'b1};
            @(posedge clk) tx_sample_valid <= 0;
            wait_hi(tx_sample_out_valid, 4);
            sec = rows[i].p ? rows[i].pg : rows[i].bg;
            e = ({16'h0, rows[i].s} * sec) >> 8;
            mid = e[15:0];
            e = ({16'h0, mid} * rows[i].gg) >> 8;
            check("sample out", {16'h0, tx_sample_out}, e);
        end
        // two reads exactly one tick apart
        cpu.rd(OFS_FREE_TIMER, d);
        repeat (TICK_CYCLES - 3) @(posedge clk);
        cpu.rd(OFS_FREE_TIMER, e);
        check("timer step", e[31:12], d[31:12] + 20'h1);
        t = e[31:12] + 20'h3;
        cpu.arm(t, 8'hff);
        cpu.rd(OFS_ORDER, d);
        check("order armed", d[ORDER_BIT], 1'b1);
        cpu.rd(OFS_START_TIME, d);
        check("start time", d, {t, 12'h000});
        wait_hi(tx_start, 4 * TICK_CYCLES);
        cpu.rd(OFS_FREE_TIMER, d);
        check("launch time", d[31:12], t);
        cpu.rd(OFS_ORDER, d);
        check("order sending", d[ORDER_BIT], 1'b0);
        cpu.wr(OFS_ORDER, 32'h00000004, 4'hf);
        cpu.rd(OFS_ORDER, d);
        check("order refused", d[ORDER_BIT], 1'b0);
        @(posedge clk) tx_done <= 1;
        @(posedge clk) tx_done <= 0;
        cpu.rd(OFS_ORDER, d);
        check("order done", d[ORDER_BIT], 1'b1);
        // preamble, correlation, then back-to-back symbols
        @(posedge clk) {rx_preamble_seen, rx_corr_valid, rx_corr_level} <= {2'b11, 16'hbeef};
        @(posedge clk) {rx_preamble_seen, rx_corr_valid} <= 2'b00;
        // the launch tick has not ended yet, so the stamp is the launch time
        cpu.wr(OFS_RX_STAMP, 32'hfffff000, 4'hf);
        cpu.rd(OFS_RX_STAMP, d);
        check("rx stamp", d, {t, 12'h000});
        cpu.rd(OFS_RX_CORR, d);
        check("correlation", d, 32'h0000beef);
        foreach (st[i]) @(posedge clk) {rx_symbol_valid, rx_symbol_strength} <= {1'b1, st[i]};
        @(posedge clk) rx_symbol_valid <= 0;
        cpu.rd(OFS_STR_MIN, d);
        check("min held", d, 32'h000000ff);
        @(posedge clk) rx_msg_end <= 1;
        @(posedge clk) rx_msg_end <= 0;
        cpu.rd(OFS_STR_MIN, d);
        check("min", d, 32'h0000000a);
        cpu.rd(OFS_STR_AVG, d);
        check("average", d, 32'h00000014);
        // second reset in mid-run
        @(posedge clk) reset_n <= 0;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        cpu.rd(OFS_STR_MIN, d);
        check("min after reset", d, 32'h000000ff);
        stop_test();
    end
endmodule // tb
